// file: design/mpfs_pin_function_select.sv
// multipurpose pin function select: mode word, pin muxes, level readback
`include "mpfs_params.svh"
module mpfs_pin_function_select (
  // clock, reset, enable
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  input  wire logic                        i_ce,
  // command interface
  input  wire mpfs_pkg::mpfs_cmd_t         i_cmd,
  input  wire logic [7:0]                  i_pin_output_data,
  // block inputs
  input  wire mpfs_pkg::mpfs_drive_status_t i_drive_status,
  input  wire logic [3:0]                  i_sync_pulse,
  input  wire logic [3:0]                  i_compare_result,
  // multipurpose pins
  input  wire logic [7:0]                  i_multipurpose_pins,
  output logic [7:0]                       o_multipurpose_pins,
  output logic [7:0]                       o_multipurpose_pins_oe,
  // to other blocks and status
  output logic [15:0]                      o_pin_function_mode,
  output logic [15:0]                      o_compare_mode_setting,
  output logic [7:0]                       o_pin_level_status,
  output logic [7:0]                       o_sync_trigger_rise,
  output logic [7:0]                       o_sync_trigger_fall,
  output logic [7:0]                       o_sync_input_valid,
  output logic [1:0]                       o_ext_drive_in,
  output logic [1:0]                       o_ext_drive_valid
);
  import mpfs_pkg::*;

  logic [15:0] pin_function_mode_reg;
  logic [15:0] compare_mode_setting_reg;
  logic [7:0]  level_w;
  logic [7:0]  level_prev_reg;
  logic [7:0]  special_w;
  logic [7:0]  status_w;

  // field n sits at bits 2n+1:2n
  function automatic mpfs_fn_t field_of(input logic [15:0] mode, input int n);
    return mpfs_fn_t'(mode[n*`MPFS_FIELD_W +: `MPFS_FIELD_W]);
  endfunction

  function automatic logic is_input(input logic [15:0] mode, input int n);
    return field_of(mode, n) == MPFS_FN_INPUT;
  endfunction

  // host places data word before the command, so data is stable here
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      pin_function_mode_reg <= `MPFS_PIN_MODE_RESET;
    end else if (i_ce && i_cmd.cmd_write && i_cmd.command_word == `MPFS_CMD_PIN_MODE) begin
      pin_function_mode_reg <= i_cmd.write_data_word;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      compare_mode_setting_reg <= `MPFS_CMP_MODE_RESET;
    end else if (i_ce && i_cmd.cmd_write && i_cmd.command_word == `MPFS_CMD_CMP_MODE) begin
      compare_mode_setting_reg <= i_cmd.write_data_word;
    end
  end

  assign status_w  = {i_drive_status.acc_dec, i_drive_status.acc_const, i_drive_status.acc_inc,
                      i_drive_status.decel, i_drive_status.const_speed, i_drive_status.accel,
                      i_drive_status.error, i_drive_status.driving};
  // compare results use the compare mode setting inside the compare unit
  assign special_w = {i_compare_result, i_sync_pulse};

  genvar g;
  generate
    for (g = 0; g < `MPFS_NPINS; g++) begin : g_pin
      mpfs_pin_cell u_cell (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_ce       (i_ce),
        .i_fn       (field_of(pin_function_mode_reg, g)),
        .i_out_data (i_pin_output_data[g]),
        .i_status   (status_w[g]),
        .i_special  (special_w[g]),
        .i_pin      (i_multipurpose_pins[g]),
        .o_pin      (o_multipurpose_pins[g]),
        .o_pin_oe   (o_multipurpose_pins_oe[g]),
        .o_level    (level_w[g])
      );
    end
  endgenerate

  // level readback and edge detection for sync action sources
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      level_prev_reg      <= 8'h00;
      o_pin_level_status  <= 8'h00;
      o_sync_trigger_rise <= 8'h00;
      o_sync_trigger_fall <= 8'h00;
      o_sync_input_valid  <= 8'h00;
    end else if (i_ce) begin
      level_prev_reg     <= level_w;
      o_pin_level_status <= level_w;
      for (int n = 0; n < `MPFS_NPINS; n++) begin
        o_sync_input_valid[n]  <= is_input(pin_function_mode_reg, n);
        o_sync_trigger_rise[n] <= is_input(pin_function_mode_reg, n) && level_w[n] && !level_prev_reg[n];
        o_sync_trigger_fall[n] <= is_input(pin_function_mode_reg, n) && !level_w[n] && level_prev_reg[n];
      end
    end
  end

  // pins 4 and 5 as external drive inputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_ext_drive_in    <= 2'h0;
      o_ext_drive_valid <= 2'h0;
    end else if (i_ce) begin
      o_ext_drive_in    <= {level_w[`MPFS_EXT_PIN_HI], level_w[`MPFS_EXT_PIN_LO]};
      o_ext_drive_valid <= {is_input(pin_function_mode_reg, `MPFS_EXT_PIN_HI),
                            is_input(pin_function_mode_reg, `MPFS_EXT_PIN_LO)};
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin_function_mode    <= `MPFS_PIN_MODE_RESET;
      o_compare_mode_setting <= `MPFS_CMP_MODE_RESET;
    end else if (i_ce) begin
      o_pin_function_mode    <= pin_function_mode_reg;
      o_compare_mode_setting <= compare_mode_setting_reg;
    end
  end

  sequence s_load_cmd;
    i_ce && i_cmd.cmd_write && i_cmd.command_word == `MPFS_CMD_PIN_MODE;
  endsequence

  sequence s_cmp_cmd;
    i_ce && i_cmd.cmd_write && i_cmd.command_word == `MPFS_CMD_CMP_MODE;
  endsequence

  property p_load;
    @(posedge i_clk) disable iff (i_rst)
    s_load_cmd |=> (pin_function_mode_reg == $past(i_cmd.write_data_word));
  endproperty
  a_load: assert property (p_load) else $error("mode word not loaded");

  property p_cmp_load;
    @(posedge i_clk) disable iff (i_rst)
    s_cmp_cmd |=> (compare_mode_setting_reg == $past(i_cmd.write_data_word));
  endproperty
  a_cmp_load: assert property (p_cmp_load) else $error("compare mode word not loaded");

  // refused codes and frozen cycles must leave the mode word alone
  property p_hold;
    @(posedge i_clk) disable iff (i_rst)
    !(i_ce && i_cmd.cmd_write && i_cmd.command_word == `MPFS_CMD_PIN_MODE) |=> $stable(pin_function_mode_reg);
  endproperty
  a_hold: assert property (p_hold) else $error("mode word changed");

  property p_freeze;
    @(posedge i_clk) disable iff (i_rst)
    !i_ce |=> ($stable(compare_mode_setting_reg) && $stable(o_multipurpose_pins_oe));
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while enable low");

  property p_mode_copy;
    @(posedge i_clk) disable iff (i_rst)
    i_ce |=> (o_pin_function_mode == $past(pin_function_mode_reg));
  endproperty
  a_mode_copy: assert property (p_mode_copy) else $error("mode word copy stale");

  property p_rst_mode;
    @(posedge i_clk) i_rst |=>
      (pin_function_mode_reg == `MPFS_PIN_MODE_RESET && compare_mode_setting_reg == `MPFS_CMP_MODE_RESET);
  endproperty
  a_rst_mode: assert property (p_rst_mode) else $error("mode words not cleared");

  property p_rst_cmp;
    @(posedge i_clk) i_rst |=> (o_compare_mode_setting == `MPFS_CMP_MODE_RESET);
  endproperty
  a_rst_cmp: assert property (p_rst_cmp) else $error("compare mode not cleared");

  property p_status_pin0;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && field_of(pin_function_mode_reg, 0) == MPFS_FN_STATUS) |=>
      (o_multipurpose_pins[0] == $past(i_drive_status.driving));
  endproperty
  a_status_pin0: assert property (p_status_pin0) else $error("driving status missing");

  property p_status_pin7;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && field_of(pin_function_mode_reg, 7) == MPFS_FN_STATUS) |=>
      (o_multipurpose_pins[7] == $past(i_drive_status.acc_dec));
  endproperty
  a_status_pin7: assert property (p_status_pin7) else $error("decreasing status missing");

  property p_sync_pin0;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && field_of(pin_function_mode_reg, 0) == MPFS_FN_SYNCMP) |=>
      (o_multipurpose_pins[0] == $past(i_sync_pulse[0]));
  endproperty
  a_sync_pin0: assert property (p_sync_pin0) else $error("sync pulse missing");

  property p_cmp_pin4;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && field_of(pin_function_mode_reg, 4) == MPFS_FN_SYNCMP) |=>
      (o_multipurpose_pins[4] == $past(i_compare_result[0]));
  endproperty
  a_cmp_pin4: assert property (p_cmp_pin4) else $error("compare result missing");

  // a frozen cycle keeps a pulse up, so only judge freshly made pulses
  property p_rise;
    @(posedge i_clk) disable iff (i_rst)
    (o_sync_trigger_rise[0] && $past(i_ce)) |->
      (o_pin_level_status[0] && !$past(o_pin_level_status[0]) && o_sync_input_valid[0]);
  endproperty
  a_rise: assert property (p_rise) else $error("bad rising trigger");

  property p_fall;
    @(posedge i_clk) disable iff (i_rst)
    (o_sync_trigger_fall[0] && $past(i_ce)) |->
      (!o_pin_level_status[0] && $past(o_pin_level_status[0]) && o_sync_input_valid[0]);
  endproperty
  a_fall: assert property (p_fall) else $error("bad falling trigger");

  property p_no_trig_on_output;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && !is_input(pin_function_mode_reg, 0)) |=>
      !(o_sync_trigger_rise[0] || o_sync_trigger_fall[0] || o_sync_input_valid[0]);
  endproperty
  a_no_trig_on_output: assert property (p_no_trig_on_output) else $error("trigger on non-input");

  property p_level;
    @(posedge i_clk) disable iff (i_rst)
    i_ce |=> (o_pin_level_status == $past(level_w));
  endproperty
  a_level: assert property (p_level) else $error("level status stale");

  property p_ext_in;
    @(posedge i_clk) disable iff (i_rst)
    i_ce |=> (o_ext_drive_in == $past(level_w[`MPFS_EXT_PIN_HI:`MPFS_EXT_PIN_LO]));
  endproperty
  a_ext_in: assert property (p_ext_in) else $error("ext drive level stale");

  property p_ext_valid;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && !is_input(pin_function_mode_reg, `MPFS_EXT_PIN_HI)) |=> !o_ext_drive_valid[1];
  endproperty
  a_ext_valid: assert property (p_ext_valid) else $error("ext drive valid on non-input");
endmodule

// file: shared/mpfs_params.svh
// constants for the multipurpose pin function select block
`ifndef MPFS_PARAMS_SVH
`define MPFS_PARAMS_SVH
`define MPFS_CMD_PIN_MODE    8'h21
`define MPFS_CMD_CMP_MODE    8'h20
`define MPFS_PIN_MODE_RESET  16'h0000
`define MPFS_CMP_MODE_RESET  16'h0000
`define MPFS_FIELD_W         2
`define MPFS_NPINS           8
`define MPFS_EXT_PIN_LO      4
`define MPFS_EXT_PIN_HI      5
`endif

// file: shared/mpfs_pkg.sv
// types for the multipurpose pin function select block
package mpfs_pkg;
  typedef enum logic [1:0] {
    MPFS_FN_INPUT  = 2'h0,
    MPFS_FN_OUTPUT = 2'h1,
    MPFS_FN_STATUS = 2'h2,
    MPFS_FN_SYNCMP = 2'h3
  } mpfs_fn_t;

  typedef struct packed {
    logic driving;
    logic error;
    logic accel;
    logic const_speed;
    logic decel;
    logic acc_inc;
    logic acc_const;
    logic acc_dec;
  } mpfs_drive_status_t;

  typedef struct packed {
    logic       cmd_write;
    logic [7:0] command_word;
    logic [15:0] write_data_word;
  } mpfs_cmd_t;
endpackage

// file: design/mpfs_pin_cell.sv
// one multipurpose pin: function mux and input synchroniser
module mpfs_pin_cell
  import mpfs_pkg::*;
(
  // clock, reset and enable
  input  wire logic     i_clk,
  input  wire logic     i_rst,
  input  wire logic     i_ce,
  // function select
  input  wire mpfs_fn_t i_fn,
  input  wire logic     i_out_data,
  input  wire logic     i_status,
  input  wire logic     i_special,
  // pin
  input  wire logic     i_pin,
  output logic          o_pin,
  output logic          o_pin_oe,
  output logic          o_level
);
  logic meta_reg;
  logic level_reg;

  // first stage read only by the second
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg  <= 1'b0;
      level_reg <= 1'b0;
    end else if (i_ce) begin
      meta_reg  <= i_pin;
      level_reg <= meta_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pin    <= 1'b0;
      o_pin_oe <= 1'b0;
    end else if (i_ce) begin
      unique case (i_fn)
        MPFS_FN_INPUT: begin
          o_pin    <= 1'b0;
          o_pin_oe <= 1'b0;
        end
        MPFS_FN_OUTPUT: begin
          o_pin    <= i_out_data;
          o_pin_oe <= 1'b1;
        end
        MPFS_FN_STATUS: begin
          o_pin    <= i_status;
          o_pin_oe <= 1'b1;
        end
        MPFS_FN_SYNCMP: begin
          o_pin    <= i_special;
          o_pin_oe <= 1'b1;
        end
      endcase
    end
  end

  assign o_level = level_reg;

  // output enable follows the selected function one cycle later
  property p_oe_follows_fn;
    @(posedge i_clk) disable iff (i_rst)
    i_ce |=> (o_pin_oe == ($past(i_fn) != MPFS_FN_INPUT));
  endproperty
  a_oe_follows_fn: assert property (p_oe_follows_fn) else $error("pin enable mismatch");

  property p_out_data;
    @(posedge i_clk) disable iff (i_rst)
    (i_ce && i_fn == MPFS_FN_OUTPUT) |=> (o_pin == $past(i_out_data));
  endproperty
  a_out_data: assert property (p_out_data) else $error("output data not driven");
endmodule

// file: sim/mpfs_pin_partner.sv
// external pin circuitry model resolving each multipurpose pin wire
module mpfs_pin_partner (
  // device side
  input  wire logic [7:0] i_dev_pin,
  input  wire logic [7:0] i_dev_oe,
  // outside source
  input  wire logic [7:0] i_ext_level,
  output logic [7:0]      o_wire
);
  timeunit 1ns;
  timeprecision 1ps;
  // device wins where it drives, so a wrong enable shows up as a wrong level
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      o_wire[n] = i_dev_oe[n] ? i_dev_pin[n] : i_ext_level[n];
    end
  end
endmodule

// file: sim/test_mpfs_pin_function_select.sv
// self-checking bench for the multipurpose pin function select block
module test_mpfs_pin_function_select
  import mpfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0, i_rst = 1'b1, i_ce = 1'b1;
  mpfs_cmd_t i_cmd = '0;
  mpfs_drive_status_t i_drive_status = mpfs_drive_status_t'(8'hC1);
  logic [7:0] i_pin_output_data = 8'h5A, ext = 8'h00, pins, pout, oe, lvl, rise, fall, valid;
  logic [3:0] i_sync_pulse = 4'h5, i_compare_result = 4'hA;
  logic [15:0] mode, cmode;
  logic [1:0] ext_in, ext_valid;
  int fails = 0, compares = 0, cyc = 0;
  logic [7:0] exp_pins [4] = '{8'h00, 8'h5A, 8'h83, 8'hA5};

  mpfs_pin_function_select mpfs_pin_function_select_i (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cmd(i_cmd), .i_pin_output_data(i_pin_output_data),
    .i_drive_status(i_drive_status), .i_sync_pulse(i_sync_pulse), .i_compare_result(i_compare_result),
    .i_multipurpose_pins(pins), .o_multipurpose_pins(pout), .o_multipurpose_pins_oe(oe),
    .o_pin_function_mode(mode), .o_compare_mode_setting(cmode), .o_pin_level_status(lvl),
    .o_sync_trigger_rise(rise), .o_sync_trigger_fall(fall), .o_sync_input_valid(valid),
    .o_ext_drive_in(ext_in), .o_ext_drive_valid(ext_valid));
  mpfs_pin_partner mpfs_pin_partner_i (.i_dev_pin(pout), .i_dev_oe(oe), .i_ext_level(ext), .o_wire(pins));

  always #2 i_clk = ~i_clk;
  // run ceiling well above the roughly 100 cycles the scenarios need
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      end_sim();
    end
  end

  task automatic end_sim();
    if (fails == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic cmd(logic [7:0] code, logic [15:0] data);
    @(posedge i_clk);
    i_cmd <= '{cmd_write: 1'b1, command_word: code, write_data_word: data};
    @(posedge i_clk);
    i_cmd.cmd_write <= 1'b0;
    repeat (5) @(posedge i_clk);
    #1;
  endtask
  task automatic t_input();
    bit seen = 0;
    @(posedge i_clk) ext <= 8'h3C;
    cmd(8'h21, 16'h0000);
    chk("level", 16'h003C, lvl);
    chk("in_valid", 16'h00FF, valid);
    chk("ext_in", 16'h0003, ext_in);
    chk("ext_valid", 16'h0003, ext_valid);
    @(posedge i_clk) ext <= 8'h3D;
    repeat (8) @(posedge i_clk) seen |= rise[0];
    chk("rise0", 16'h0001, seen);
    @(posedge i_clk) ext <= 8'h3C;
    seen = 1'b0;
    repeat (8) @(posedge i_clk) seen |= fall[0];
    chk("fall0", 16'h0001, seen);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++) begin
      cmd(8'h21, {8{m[1:0]}});
      chk("mode", {8{m[1:0]}}, mode);
      chk("oe", (m == 0) ? 16'h0000 : 16'h00FF, oe);
      if (m != 0) chk("pins", exp_pins[m], pins);
    end
  endtask
  task automatic t_mixed();
    cmd(8'h21, 16'hE4E4);
    chk("mix_oe", 16'h00EE, oe);
    chk("mix_valid", 16'h0011, valid);
    chk("mix_pins", 16'h0082, pout & 8'hEE);
  endtask
  task automatic t_refuse_reset();
    cmd(8'h22, 16'hFFFF);
    chk("bad_code", 16'hE4E4, mode);
    @(posedge i_clk) i_ce <= 1'b0;
    cmd(8'h21, 16'h0000);
    @(posedge i_clk) i_ce <= 1'b1;
    #1;
    chk("ce_low", 16'hE4E4, mode);
    cmd(8'h20, 16'h1232);
    chk("cmp_mode", 16'h1232, cmode);
    @(posedge i_clk) i_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (3) @(posedge i_clk);
    #1;
    chk("cmp_rst", 16'h0000, cmode);
    chk("mode_rst", 16'h0000, mode);
    chk("oe_rst", 16'h0000, oe);
  endtask

  task automatic t_reset();
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    @(posedge i_clk);
    #1;
    chk("mode0", 16'h0000, mode);
    chk("cmode0", 16'h0000, cmode);
    chk("oe0", 16'h0000, oe);
  endtask

  initial begin
    t_reset();
    t_input();
    t_modes();
    t_mixed();
    t_refuse_reset();
    end_sim();
  end
endmodule
